// ---- phy_status_led_irq_regs.sv ----
// management registers: link status, receive-error tally, indicators, drive and interrupt
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module phy_status_led_irq_regs #(
    parameter int TICK_CYCLES = phy_regs_pkg::TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire phy_regs_pkg::reg_req_type reg_req_in,
    output logic [15:0] reg_rdata_out,
    input wire phy_regs_pkg::line_state_type line_in,
    input wire logic rx_er_in,
    input wire logic [7:0] event_in,
    input wire logic mdio_data_in,
    input wire logic mdio_drive_in,
    output logic mdio_o_out,
    output logic mdio_oe_out,
    output logic indicator_one_out,
    output logic indicator_two_out,
    output logic irq_out
);
    import phy_regs_pkg::*;

    // counter width follows the tick length so a longer tick cannot overflow it
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    logic [15:0] receive_error_tally;
    logic [15:0] indicator_function_select;
    logic [15:0] indicator_behaviour;
    logic [15:0] management_output_drive;
    logic [15:0] indicator_scheme_select;
    logic [7:0] irq_enable;
    logic [7:0] irq_status;
    logic irq_invert;
    logic [15:0] next_rdata;
    logic wr_hit;
    logic rd_tally;
    logic rd_irq;
    logic wr_func;
    logic wr_behav;
    logic wr_drive;
    logic wr_scheme;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                            input logic en);
        merge16 = en ? val : old;
    endfunction

    assign rd_tally = reg_req_in.rd && (reg_req_in.addr == OFS_RX_TALLY);
    assign rd_irq = reg_req_in.rd && (reg_req_in.addr == OFS_IRQ);
    assign wr_hit = reg_req_in.wr;

    // one decode per writable register so each register keeps its own process
    assign wr_func = wr_hit && (reg_req_in.addr == OFS_FUNC_SEL);
    assign wr_behav = wr_hit && (reg_req_in.addr == OFS_BEHAVIOUR);
    assign wr_drive = wr_hit && (reg_req_in.addr == OFS_DRIVE);
    assign wr_scheme = wr_hit && (reg_req_in.addr == OFS_SCHEME);

    // read mux; reserved and unmapped locations read zero
    always_comb
    begin
        next_rdata = 16'h0000;
        case (reg_req_in.addr)
            OFS_LINK_SPEED:
            begin
                next_rdata[BIT_LINK_1000] = line_in.link_1000;
                next_rdata[BIT_LINK_100] = line_in.link_100;
            end
            OFS_RX_TALLY: next_rdata = receive_error_tally;
            OFS_FUNC_SEL: next_rdata = indicator_function_select;
            OFS_BEHAVIOUR: next_rdata = indicator_behaviour;
            OFS_DRIVE: next_rdata = management_output_drive;
            OFS_SCHEME: next_rdata = indicator_scheme_select;
            OFS_IRQ: next_rdata = {irq_enable, irq_status};
            OFS_CONTROL: next_rdata[BIT_IRQ_INVERT] = irq_invert;
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_req_in.rd)
            reg_rdata_out <= next_rdata;
        else
            reg_rdata_out <= 16'h0000;
    end

    // an error in the cycle of the clearing read is counted, so none is lost
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            receive_error_tally <= RST_TALLY;
        else if (rd_tally)
            receive_error_tally <= {15'h0000, rx_er_in};
        else if (rx_er_in && receive_error_tally != 16'hffff)
            receive_error_tally <= receive_error_tally + 16'h0001;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            indicator_function_select <= RST_FUNC_SEL;
        else
            indicator_function_select <= merge16(indicator_function_select, reg_req_in.wdata,
                                                 wr_func);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            indicator_behaviour <= RST_BEHAVIOUR;
        else
            indicator_behaviour <= merge16(indicator_behaviour, reg_req_in.wdata,
                                           wr_behav);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            management_output_drive <= RST_DRIVE;
        else
            management_output_drive <= merge16(management_output_drive, reg_req_in.wdata,
                                               wr_drive);
    end

    // software should keep the scheme bit at one; clearing it hands the pins to the selections
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            indicator_scheme_select <= RST_SCHEME;
        else
            indicator_scheme_select <= merge16(indicator_scheme_select, reg_req_in.wdata,
                                               wr_scheme);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            irq_invert <= 1'b0;
        else if (wr_hit && reg_req_in.addr == OFS_CONTROL)
            irq_invert <= reg_req_in.wdata[BIT_IRQ_INVERT];
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            irq_enable <= RST_IRQ_EN;
        else if (wr_hit && reg_req_in.addr == OFS_IRQ)
            irq_enable <= reg_req_in.wdata[15:8];
    end

    // set beats clear: an event in the reading cycle stays latched for the next read
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            irq_status <= RST_IRQ_STAT;
        else if (rd_irq)
            irq_status <= event_in;
        else
            irq_status <= irq_status | event_in;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            irq_out <= 1'b0;
        else
            irq_out <= (|(irq_status & irq_enable)) ^ irq_invert;
    end

    // management data pin: open-drain only ever pulls low
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            mdio_o_out <= 1'b0;
            mdio_oe_out <= 1'b0;
        end
        else if (management_output_drive[BIT_PUSH_PULL])
        begin
            mdio_o_out <= mdio_data_in;
            mdio_oe_out <= mdio_drive_in;
        end
        else
        begin
            mdio_o_out <= 1'b0;
            mdio_oe_out <= mdio_drive_in && !mdio_data_in;
        end
    end

    // indicator timing
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic half_end;
    logic [3:0] blink_cnt;
    logic [3:0] blink_limit;
    logic blink_phase;
    logic [4:0] act_hold;
    logic [4:0] col_hold;
    logic [4:0] stretch_len;
    logic legacy;
    logic next_one;
    logic next_two;

    // ticks per blink half period: 8, 4, 2, 1 for rate codes 00..11
    function automatic logic [3:0] half_ticks(input logic [1:0] rate);
        half_ticks = 4'h1 << (2'h3 - rate);
    endfunction

    assign legacy = indicator_scheme_select[BIT_LEGACY];
    assign stretch_len = {half_ticks(indicator_behaviour[RATE_LSB +: 2]), 1'b0};

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            tick_cnt <= '0;
        else if (tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + TICK_W'(1);
    end

    assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
    assign half_end = (blink_cnt >= blink_limit - 4'h1);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            blink_cnt <= 4'h0;
            blink_phase <= 1'b0;
        end
        else if (tick)
        begin
            if (half_end)
            begin
                blink_cnt <= 4'h0;
                blink_phase <= !blink_phase;
            end
            else
                blink_cnt <= blink_cnt + 4'h1;
        end
    end

    // the new rate is picked up only when a half period ends, so no half period is cut short
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            blink_limit <= half_ticks(RST_BEHAVIOUR[RATE_LSB +: 2]);
        else if (tick && half_end)
            blink_limit <= half_ticks(indicator_behaviour[RATE_LSB +: 2]);
    end

    // each activity or collision sighting holds the indicator for the stretch time
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            act_hold <= 5'h00;
        else if (line_in.activity)
            act_hold <= stretch_len;
        else if (tick && act_hold != 5'h00)
            act_hold <= act_hold - 5'h01;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            col_hold <= 5'h00;
        else if (line_in.collision)
            col_hold <= stretch_len;
        else if (tick && col_hold != 5'h00)
            col_hold <= col_hold - 5'h01;
    end

    // one indicator's level from its function code, display style and merge setting
    function automatic logic drive_level(input logic [3:0] code, input logic stretch,
                                         input logic separate, input logic [4:0] act_h,
                                         input logic [4:0] col_h, input logic phase,
                                         input line_state_type ln);
        logic act_vis;
        logic col_vis;
        act_vis = stretch ? (act_h != 5'h00) : ((act_h != 5'h00) && phase);
        col_vis = stretch ? (col_h != 5'h00) : ((col_h != 5'h00) && phase);
        case (code)
            FN_LINK_1000: drive_level = ln.link_1000;
            FN_LINK_100: drive_level = ln.link_100;
            FN_LINK_ACT: drive_level = separate ? ln.link_up : (ln.link_up && !act_vis);
            FN_ACTIVITY: drive_level = act_vis;
            FN_DUPLEX_COL: drive_level = separate ? ln.duplex : (ln.duplex && !col_vis);
            FN_COLLISION: drive_level = col_vis;
            default: drive_level = 1'b0;
        endcase
    endfunction

    always_comb
    begin
        if (legacy)
        begin
            // fixed scheme: one shows link, two shows activity blinking
            next_one = line_in.link_up;
            next_two = (act_hold != 5'h00) && blink_phase;
        end
        else
        begin
            next_one = drive_level(indicator_function_select[FUNC_ONE_LSB +: 4],
                                   indicator_behaviour[BIT_STRETCH_ONE],
                                   indicator_behaviour[BIT_SEPARATE_ONE],
                                   act_hold, col_hold, blink_phase, line_in);
            next_two = drive_level(indicator_function_select[FUNC_TWO_LSB +: 4],
                                   indicator_behaviour[BIT_STRETCH_TWO],
                                   indicator_behaviour[BIT_SEPARATE_TWO],
                                   act_hold, col_hold, blink_phase, line_in);
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            indicator_one_out <= 1'b0;
        else
            indicator_one_out <= next_one;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            indicator_two_out <= 1'b0;
        else
            indicator_two_out <= next_two;
    end
endmodule

// ---- phy_regs_pkg.sv ----
// constants and types of the phy management register group
package phy_regs_pkg;
    localparam logic [4:0] OFS_LINK_SPEED = 5'h13;
    localparam logic [4:0] OFS_RX_TALLY = 5'h15;
    localparam logic [4:0] OFS_FUNC_SEL = 5'h16;
    localparam logic [4:0] OFS_BEHAVIOUR = 5'h17;
    localparam logic [4:0] OFS_DRIVE = 5'h19;
    localparam logic [4:0] OFS_SCHEME = 5'h1a;
    localparam logic [4:0] OFS_IRQ = 5'h1b;
    localparam logic [4:0] OFS_CONTROL = 5'h1f;

    localparam logic [15:0] RST_FUNC_SEL = 16'h0021;
    localparam logic [15:0] RST_BEHAVIOUR = 16'h1000;
    localparam logic [15:0] RST_DRIVE = 16'h0000;
    localparam logic [15:0] RST_SCHEME = 16'h4000;
    localparam logic [15:0] RST_TALLY = 16'h0000;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_IRQ_STAT = 8'h00;

    localparam int BIT_LINK_1000 = 1;
    localparam int BIT_LINK_100 = 0;
    localparam int BIT_LEGACY = 14;
    localparam int BIT_PUSH_PULL = 1;
    localparam int BIT_IRQ_INVERT = 14;
    localparam int BIT_STRETCH_TWO = 6;
    localparam int BIT_STRETCH_ONE = 5;
    localparam int BIT_SEPARATE_TWO = 1;
    localparam int BIT_SEPARATE_ONE = 0;
    localparam int RATE_LSB = 10;
    localparam int FUNC_TWO_LSB = 4;
    localparam int FUNC_ONE_LSB = 0;

    // timing base: one tick per 25 ms, the half period of the fastest blink
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_US = 25000;
    localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        FN_LINK_1000,
        FN_LINK_ACT,
        FN_ACTIVITY,
        FN_DUPLEX_COL,
        FN_COLLISION,
        FN_LINK_100,
        FN_OFF
    } func_code_type;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic link_1000;
        logic link_100;
        logic link_up;
        logic duplex;
        logic activity;
        logic collision;
    } line_state_type;
endpackage

// ---- phy_regs_monitor.sv ----
// port assertions for the management register group
`timescale 1ns/1ns
module phy_regs_monitor #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire phy_regs_pkg::reg_req_type reg_req_in,
    input wire logic [15:0] reg_rdata_out,
    input wire phy_regs_pkg::line_state_type line_in,
    input wire logic rx_er_in,
    input wire logic [7:0] event_in,
    input wire logic mdio_data_in,
    input wire logic mdio_drive_in,
    input wire logic mdio_o_out,
    input wire logic mdio_oe_out,
    input wire logic indicator_one_out,
    input wire logic indicator_two_out,
    input wire logic irq_out
);
    import phy_regs_pkg::*;
    logic [15:0] tally, fsel, behav, drv, scheme, exp_rd;
    logic [7:0] en, st;
    logic inv, irqm;
    wire logic rd = reg_req_in.rd;
    wire logic [4:0] a = reg_req_in.addr;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge mclk_in)
        if (!rst_n_in)
            tally <= RST_TALLY;
        else if (rd && a == OFS_RX_TALLY)
            tally <= {15'h0, rx_er_in};
        else if (rx_er_in && tally != 16'hffff)
            tally <= tally + 16'h1;
    // set wins over the clear of a read in the same cycle
    always_ff @(posedge mclk_in)
        if (!rst_n_in)
        begin
            st <= RST_IRQ_STAT;
            irqm <= 1'b0;
        end
        else
        begin
            st <= ((rd && a == OFS_IRQ) ? 8'h00 : st) | event_in;
            irqm <= (|(st & en)) ^ inv;
        end
    always_ff @(posedge mclk_in)
        if (!rst_n_in)
        begin
            fsel <= RST_FUNC_SEL;
            behav <= RST_BEHAVIOUR;
            drv <= RST_DRIVE;
            scheme <= RST_SCHEME;
            en <= RST_IRQ_EN;
            inv <= 1'b0;
        end
        else if (reg_req_in.wr)
            case (a)
                OFS_FUNC_SEL: fsel <= reg_req_in.wdata;
                OFS_BEHAVIOUR: behav <= reg_req_in.wdata;
                OFS_DRIVE: drv <= reg_req_in.wdata;
                OFS_SCHEME: scheme <= reg_req_in.wdata;
                OFS_IRQ: en <= reg_req_in.wdata[15:8];
                OFS_CONTROL: inv <= reg_req_in.wdata[BIT_IRQ_INVERT];
                default: ;
            endcase
    always_comb
        case (a)
            OFS_LINK_SPEED: exp_rd = {14'h0, line_in.link_1000, line_in.link_100};
            OFS_RX_TALLY: exp_rd = tally;
            OFS_FUNC_SEL: exp_rd = fsel;
            OFS_BEHAVIOUR: exp_rd = behav;
            OFS_DRIVE: exp_rd = drv;
            OFS_SCHEME: exp_rd = scheme;
            OFS_IRQ: exp_rd = {en, st};
            OFS_CONTROL: exp_rd = {1'b0, inv, 14'h0};
            default: exp_rd = 16'h0;
        endcase
    a_link_status: assert property (rd && a == OFS_LINK_SPEED && $stable(line_in)
        |=> reg_rdata_out == $past(exp_rd)) else $error("link status read wrong");
    a_tally_read: assert property (rd && a == OFS_RX_TALLY
        |=> reg_rdata_out == $past(exp_rd)) else $error("tally read wrong");
    a_led_config: assert property (rd && (a == OFS_FUNC_SEL || a == OFS_BEHAVIOUR)
        |=> reg_rdata_out == $past(exp_rd)) else $error("indicator setting read wrong");
    a_drive_scheme: assert property (rd && (a == OFS_DRIVE || a == OFS_SCHEME)
        |=> reg_rdata_out == $past(exp_rd)) else $error("drive or scheme read wrong");
    a_irq_read: assert property (rd && (a == OFS_IRQ || a == OFS_CONTROL)
        |=> reg_rdata_out == $past(exp_rd)) else $error("interrupt register read wrong");
    a_rdata_idle: assert property (!rd |=> reg_rdata_out == 16'h0)
        else $error("read data outside its cycle");
    a_irq_level: assert property (inv == $past(inv) |-> irq_out == irqm)
        else $error("interrupt output wrong");
    a_open_drain: assert property (!drv[BIT_PUSH_PULL] |=> !mdio_o_out &&
        mdio_oe_out == ($past(mdio_drive_in) && !$past(mdio_data_in))) else $error("open drain wrong");
    a_push_pull: assert property (drv[BIT_PUSH_PULL] |=> mdio_oe_out == $past(mdio_drive_in)
        && mdio_o_out == $past(mdio_data_in)) else $error("push pull wrong");
    a_legacy_led: assert property (scheme[BIT_LEGACY] |=>
        indicator_one_out == $past(line_in.link_up)) else $error("legacy indicator wrong");
    a_ext_led: assert property (!scheme[BIT_LEGACY] && fsel[3:0] == 4'h0 |=>
        indicator_one_out == $past(line_in.link_1000)) else $error("extended indicator wrong");
    c_irq_raised: cover property ($rose(irq_out));
    c_tally_full: cover property (rd && a == OFS_RX_TALLY && tally == 16'hffff);
    c_push_pull: cover property (drv[BIT_PUSH_PULL] && mdio_oe_out);
endmodule
bind phy_status_led_irq_regs phy_regs_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_phy_regs_monitor (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .line_in(line_in), .rx_er_in(rx_er_in),
    .event_in(event_in), .mdio_data_in(mdio_data_in), .mdio_drive_in(mdio_drive_in),
    .mdio_o_out(mdio_o_out), .mdio_oe_out(mdio_oe_out), .indicator_one_out(indicator_one_out),
    .indicator_two_out(indicator_two_out), .irq_out(irq_out));

// ---- mdio_bus_model.sv ----
// far side of the management data wire, with its pull-up
`timescale 1ns/1ns
module mdio_bus_model (
    input wire logic o_in,
    input wire logic oe_in,
    output logic line_out
);
    // a released wire rises to the pull-up instead of keeping the last bit
    assign line_out = oe_in ? o_in : 1'b1;
endmodule

// ---- tb_top.sv ----
// self-checking bench for the management register group
`timescale 1ns/1ns
module tb_top;
    import phy_regs_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    reg_req_type req = '0;
    line_state_type line = '0;
    logic rx_er = 1'b0;
    logic [7:0] ev = 8'h00;
    logic md_data = 1'b0;
    logic md_drive = 1'b0;
    logic [15:0] rdata;
    logic md_o, md_oe, led_one, led_two, irq, wire_lvl;
    logic rd_q = 1'b0;
    logic [15:0] expq[$];
    int fails = 0;
    int checked = 0;
    always #25 mclk_in = ~mclk_in;
    phy_status_led_irq_regs #(.TICK_CYCLES(4)) u_phy_status_led_irq_regs (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .line_in(line), .rx_er_in(rx_er), .event_in(ev), .mdio_data_in(md_data),
        .mdio_drive_in(md_drive), .mdio_o_out(md_o), .mdio_oe_out(md_oe),
        .indicator_one_out(led_one), .indicator_two_out(led_two), .irq_out(irq));
    mdio_bus_model u_mdio_bus_model (.o_in(md_o), .oe_in(md_oe), .line_out(wire_lvl));
    task automatic tally_and_finish;
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_word(input string w, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n)
        begin
            req.wr <= 1'b0;
            req.rd <= 1'b0;
            @(posedge mclk_in);
        end
    endtask
    // sampled at the falling edge so the rising-edge updates have landed
    task automatic chk_bit(input string w, input logic e, ref logic s, input int n);
        cyc(n);
        @(negedge mclk_in);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s expected %b seen %b", w, e, s);
        end
        @(posedge mclk_in);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        req.rd <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        expq.push_back(e);
        req.addr <= a;
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge mclk_in);
    endtask
    always @(posedge mclk_in)
    begin
        if (rd_q)
            cmp_word("read data", expq.pop_front(), rdata);
        rd_q <= req.rd;
    end
    initial
    begin
        repeat (80000) @(posedge mclk_in);
        fails++;
        tally_and_finish;
    end
    initial
    begin
        static logic [4:0] ofs[4] = '{OFS_FUNC_SEL, OFS_BEHAVIOUR, OFS_DRIVE, OFS_SCHEME};
        static logic [15:0] rv[4] = '{RST_FUNC_SEL, RST_BEHAVIOUR, RST_DRIVE, RST_SCHEME};
        logic [15:0] r;
        int n;
        void'($urandom(32'h12cbd9c1));
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd(ofs[i], rv[i]);
        rd(OFS_RX_TALLY, RST_TALLY);
        rd(OFS_IRQ, {RST_IRQ_EN, RST_IRQ_STAT});
        rd(5'h14, 16'h0);
        for (int i = 0; i < 4; i++)
        begin
            line.link_1000 <= i[1];
            line.link_100 <= i[0];
            cyc(2);
            rd(OFS_LINK_SPEED, {14'h0, i[1:0]});
        end
        for (int i = 0; i < 4; i++)
        begin
            r = 16'($urandom);
            wr(ofs[i], r);
            rd(ofs[i], r);
            wr(OFS_BEHAVIOUR, {4'h1, i[1:0], 10'h0});
            rd(OFS_BEHAVIOUR, {4'h1, i[1:0], 10'h0});
        end
        wr(OFS_LINK_SPEED, 16'h0);
        wr(OFS_RX_TALLY, 16'hffff);
        rd(OFS_LINK_SPEED, 16'h0003);
        rd(OFS_RX_TALLY, 16'h0);
        wr(OFS_SCHEME, 16'h0);
        wr(OFS_FUNC_SEL, 16'h0);
        chk_bit("indicator one", 1'b1, led_one, 2);
        chk_bit("indicator two", 1'b1, led_two, 0);
        wr(OFS_FUNC_SEL, 16'h0022);
        wr(OFS_BEHAVIOUR, 16'h0c40);
        line.activity <= 1'b1;
        cyc(1);
        line.activity <= 1'b0;
        chk_bit("indicator two", 1'b1, led_two, 2);
        chk_bit("indicator two", 1'b0, led_two, 12);
        wr(OFS_SCHEME, RST_SCHEME);
        line.link_up <= 1'b1;
        chk_bit("indicator one", 1'b1, led_one, 2);
        wr(OFS_DRIVE, 16'h0);
        md_drive <= 1'b1;
        md_data <= 1'b1;
        chk_bit("mdio wire", 1'b1, wire_lvl, 2);
        md_data <= 1'b0;
        chk_bit("mdio wire", 1'b0, wire_lvl, 2);
        wr(OFS_DRIVE, 16'h0002);
        md_data <= 1'b1;
        chk_bit("mdio enable", 1'b1, md_oe, 2);
        for (int m = 0; m < 2; m++)
        begin
            wr(OFS_DRIVE, m[0] ? 16'h0000 : 16'h0002);
            repeat (16)
            begin
                md_data <= 1'($urandom);
                md_drive <= 1'($urandom);
                cyc(1);
            end
        end
        n = $urandom_range(20, 1);
        rx_er <= 1'b1;
        cyc(n);
        rx_er <= 1'b0;
        cyc(1);
        rd(OFS_RX_TALLY, n[15:0]);
        rd(OFS_RX_TALLY, 16'h0);
        rx_er <= 1'b1;
        cyc(65540);
        rx_er <= 1'b0;
        cyc(1);
        rd(OFS_RX_TALLY, 16'hffff);
        rd(OFS_RX_TALLY, 16'h0);
        wr(OFS_IRQ, 16'hff00);
        for (int i = 0; i < 8; i++)
        begin
            ev <= 8'h01 << i;
            cyc(1);
            ev <= 8'h00;
            chk_bit("irq", 1'b1, irq, 3);
            rd(OFS_IRQ, {8'hff, 8'h01 << i});
            chk_bit("irq", 1'b0, irq, 3);
        end
        wr(OFS_IRQ, 16'h00ff);
        ev <= 8'hff;
        cyc(1);
        ev <= 8'h00;
        chk_bit("irq", 1'b0, irq, 3);
        wr(OFS_CONTROL, 16'h4000);
        chk_bit("irq", 1'b1, irq, 3);
        rd(OFS_CONTROL, 16'h4000);
        wr(OFS_CONTROL, 16'h0);
        rd(OFS_IRQ, 16'h00ff);
        rd(OFS_IRQ, 16'h0);
        cyc(3);
        tally_and_finish;
    end
endmodule
